// ==== clkgen_consts.vh ====
// Purpose: Shared constants for the system clock select and synthesizer control block
// Assumes: Included by bare name from each design file
// Notes: Offsets are AXI4-Lite byte addresses (index times four)
`ifndef CLKGEN_CONSTS_VH
`define CLKGEN_CONSTS_VH

// ----------------------------------------
// Register indices and byte addresses
// ----------------------------------------
`define SYS_CLK_CTRL_IDX 8'h8a
`define SYNTH_CTRL_IDX 8'ha7
`define WAKE_CTRL_IDX 8'hb0
`define SYS_CLK_CTRL_ADDR 10'h228
`define SYNTH_CTRL_ADDR 10'h29c
`define WAKE_CTRL_ADDR 10'h2c0

// ----------------------------------------
// Reset values
// ----------------------------------------
`define SYS_CLK_CTRL_RST 8'h04
`define SYNTH_CTRL_RST 8'h00

// ----------------------------------------
// System clock control fields
// ----------------------------------------
`define SCC_STOP_DEPTH 7
`define SCC_DIV_HI 6
`define SCC_DIV_LO 5
`define SCC_SCHEME 4
`define SCC_RC_HALT 3
`define SCC_XTAL_HALT 2
`define SCC_SRC_HI 1
`define SCC_SRC_LO 0

// ----------------------------------------
// Synthesizer control fields
// ----------------------------------------
`define SYN_STATUS 7
`define SYN_OUT_SEL 6
`define SYN_REG_SEL 5
`define SYN_FB_HI 4
`define SYN_FB_LO 3
`define SYN_PD_HI 2
`define SYN_PD_LO 1
`define SYN_ENABLE 0

// ----------------------------------------
// Source codes and constants
// ----------------------------------------
`define SRC_INTERNAL_RC_OSCILLATOR 2'h0
`define SRC_XTAL 2'h1
`define SRC_SUB_SYNTH 2'h2
`define SRC_RING 2'h3
`define STOP_DEEP_POWER_CONTROL_REGISTER 8'h03
`define STOP_LIGHT_POWER_CONTROL_REGISTER 8'h01
`define FB_RATIO_0 10'd616
`define FB_RATIO_1 10'd512
`define FB_RATIO_2 10'd450
`define FB_RATIO_3 10'd338
`define SYNTH_OFF_SUB_CYCLES 2'd2
`define REF_FREQ_HZ 32768

`endif

// ==== clk_divider.v ====
// Purpose: Power-of-two clock enable divider (1, 2, 4, 8)
// Assumes: tick_in is a one-cycle strobe of the source clock
// Notes: Output is a strobe, not a derived clock, to avoid gated clock skew
`timescale 1ns/100ps
`include "clkgen_consts.vh"
module clk_divider (
   aclk,
   aresetn,
   tick_in,
   div_sel,
   tick_out
);
   input wire aclk;
   input wire aresetn;
   input wire tick_in;
   input wire [1:0] div_sel;
   output reg tick_out;

   reg [2:0] cnt_ff;
   reg [2:0] limit;

   always @* begin
      case (div_sel)
         2'h0: limit = 3'h0;
         2'h1: limit = 3'h1;
         2'h2: limit = 3'h3;
         default: limit = 3'h7;
      endcase
   end

   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= 3'h0;
         tick_out <= 1'b0;
      end else begin
         tick_out <= 1'b0;
         if (tick_in) begin
            if (cnt_ff >= limit) begin
               cnt_ff <= 3'h0;
               tick_out <= 1'b1;
            end else begin
               cnt_ff <= cnt_ff + 3'h1;
            end
         end
      end
   end
endmodule // clk_divider

// ==== synth_disable_timer.v ====
// Purpose: Counts sub-oscillator ticks needed to complete a synthesizer disable
// Assumes: sub_tick is a one-cycle strobe per sub-oscillator period
// Notes: running stays high until the count finishes
`timescale 1ns/100ps
`include "clkgen_consts.vh"
module synth_disable_timer (
   aclk,
   aresetn,
   start,
   sub_tick,
   running
);
   input wire aclk;
   input wire aresetn;
   input wire start;
   input wire sub_tick;
   output wire running;

   reg [1:0] cnt_ff;

   assign running = (cnt_ff != 2'h0);

   always @(posedge aclk) begin
      if (!aresetn) begin
         cnt_ff <= 2'h0;
      end else if (start) begin
         cnt_ff <= `SYNTH_OFF_SUB_CYCLES;
      end else if (running && sub_tick) begin
         cnt_ff <= cnt_ff - 2'h1;
      end
   end
endmodule // synth_disable_timer

// ==== sys_clk_ctrl.v ====
// Purpose: System clock source select, oscillator gating and synthesizer control
// Assumes: Oscillator ticks are strobes synchronous to aclk
// Notes: Registers reached over AXI4-Lite, one aligned word each
//
// Functional notes
// RQ1: Reset selects internal RC, divide by one
// RQ2: Ring oscillator clocks timer, watchdog, debounce
// RQ3: RC divider 1/2/4/8, only for RC source
// RQ4: Scheme 0: selection applied on stop wake
// RQ5: Scheme 1: changes applied at once
// RQ6: Software keeps other fields when clearing scheme
// RQ7: RC halt bit acts only in scheme 1
// RQ8: Crystal halt resets 1, forced by fuse
// RQ9: Source select picks RC, crystal, sub/synth, ring
// RQ10: Stop depth only valid with power control 0x03
// RQ11: Status shows bypass or synthesized output
// RQ12: Output select; set on low-power interrupt
// RQ13: Enabled synthesizer core runs during bypass
// RQ14: Regulator select low-current or main in bypass
// RQ15: Feedback ratio 616/512/450/338
// RQ16: Post divider 1/2/4/8
// RQ17: Disable completes after two sub cycles
// RQ18: Sub-active: source 10, select 0, enable 0
// RQ19: Output frequency is reference times ratio over divider
`timescale 1ns/100ps
`include "clkgen_consts.vh"
module sys_clk_ctrl (
   aclk,
   aresetn,
   awaddr,
   awvalid,
   awready,
   wdata,
   wstrb,
   wvalid,
   wready,
   bresp,
   bvalid,
   bready,
   araddr,
   arvalid,
   arready,
   rdata,
   rresp,
   rvalid,
   rready,
   rc_tick,
   xtal_tick,
   sub_tick,
   synth_tick,
   ring_tick,
   crystal_input_fuse,
   power_control_register,
   stop_wake,
   low_power_irq,
   sys_clk_tick,
   sys_src,
   ring_osc_clock,
   rc_osc_run,
   xtal_osc_run,
   synth_core_run,
   synth_bypass,
   main_regulator_on,
   sub_regulator_on,
   stop_deep,
   sub_active,
   feedback_ratio,
   post_divider,
   synth_freq_hz
);
   input wire aclk;
   input wire aresetn;
   input wire [31:0] awaddr;
   input wire awvalid;
   output wire awready;
   input wire [31:0] wdata;
   input wire [3:0] wstrb;
   input wire wvalid;
   output wire wready;
   output reg [1:0] bresp;
   output reg bvalid;
   input wire bready;
   input wire [31:0] araddr;
   input wire arvalid;
   output wire arready;
   output reg [31:0] rdata;
   output reg [1:0] rresp;
   output reg rvalid;
   input wire rready;
   input wire rc_tick;
   input wire xtal_tick;
   input wire sub_tick;
   input wire synth_tick;
   input wire ring_tick;
   input wire crystal_input_fuse;
   input wire [7:0] power_control_register;
   input wire stop_wake;
   input wire low_power_irq;
   output wire sys_clk_tick;
   output reg [1:0] sys_src;
   output wire ring_osc_clock;
   output reg rc_osc_run;
   output reg xtal_osc_run;
   output reg synth_core_run;
   output reg synth_bypass;
   output reg main_regulator_on;
   output reg sub_regulator_on;
   output reg stop_deep;
   output reg sub_active;
   output reg [9:0] feedback_ratio;
   output reg [3:0] post_divider;
   output reg [31:0] synth_freq_hz;

   // ----------------------------------------
   // Registers
   // ----------------------------------------
   reg [7:0] sys_ctrl_ff;
   reg [7:0] synth_ctrl_ff;
   reg [1:0] div_act_ff;
   reg rc_halt_act_ff;
   reg xtal_halt_act_ff;
   reg wake_pend_ff;
   reg [31:0] awaddr_ff;
   reg aw_held_ff;
   reg [31:0] wdata_ff;
   reg [3:0] wstrb_ff;
   reg w_held_ff;
   reg synth_en_d_ff;

   wire do_write;
   wire [31:0] wr_addr;
   wire [31:0] wr_data;
   wire [3:0] wr_strb;
   wire wr_sys;
   wire wr_synth;
   wire wr_wake;
   wire scheme_sw;
   wire rc_div_tick;
   wire rc_gated_tick;
   wire disable_busy;
   wire [7:0] nxt_sys_ctrl;
   wire [7:0] nxt_synth_ctrl;
   wire synth_active;
   wire [31:0] vco_freq;

   // ----------------------------------------
   // AXI4-Lite write channel
   // ----------------------------------------
   // Address and data are latched independently so either may come first
   assign awready = !aw_held_ff && !bvalid;
   assign wready = !w_held_ff && !bvalid;
   assign wr_addr = aw_held_ff ? awaddr_ff : awaddr;
   assign wr_data = w_held_ff ? wdata_ff : wdata;
   assign wr_strb = w_held_ff ? wstrb_ff : wstrb;
   assign do_write = (aw_held_ff || (awvalid && awready)) &&
                     (w_held_ff || (wvalid && wready));
   assign wr_sys = do_write && (wr_addr[9:2] == `SYS_CLK_CTRL_IDX) && wr_strb[0];
   assign wr_synth = do_write && (wr_addr[9:2] == `SYNTH_CTRL_IDX) && wr_strb[0];
   assign wr_wake = do_write && (wr_addr[9:2] == `WAKE_CTRL_IDX) && wr_strb[0];

   always @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_ff <= 1'b0;
         w_held_ff <= 1'b0;
         awaddr_ff <= 32'h00000000;
         wdata_ff <= 32'h00000000;
         wstrb_ff <= 4'h0;
         bvalid <= 1'b0;
         bresp <= 2'h0;
      end else begin
         if (do_write) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid <= 1'b1;
            if (wr_addr[31:10] == 22'h000000 &&
                (wr_addr[9:2] == `SYS_CLK_CTRL_IDX || wr_addr[9:2] == `SYNTH_CTRL_IDX ||
                 wr_addr[9:2] == `WAKE_CTRL_IDX)) begin
               bresp <= 2'h0;
            end else begin
               bresp <= 2'h2;
            end
         end else begin
            if (awvalid && awready) begin
               aw_held_ff <= 1'b1;
               awaddr_ff <= awaddr;
            end
            if (wvalid && wready) begin
               w_held_ff <= 1'b1;
               wdata_ff <= wdata;
               wstrb_ff <= wstrb;
            end
            if (bvalid && bready) begin
               bvalid <= 1'b0;
            end
         end
      end
   end

   // ----------------------------------------
   // AXI4-Lite read channel
   // ----------------------------------------
   assign arready = !rvalid;

   always @(posedge aclk) begin
      if (!aresetn) begin
         rvalid <= 1'b0;
         rdata <= 32'h00000000;
         rresp <= 2'h0;
      end else if (arvalid && arready) begin
         rvalid <= 1'b1;
         rresp <= 2'h0;
         if (araddr[31:10] != 22'h000000) begin
            rdata <= 32'h00000000;
            rresp <= 2'h2;
         end else if (araddr[9:2] == `SYS_CLK_CTRL_IDX) begin
            rdata <= {24'h000000, sys_ctrl_ff};
         end else if (araddr[9:2] == `SYNTH_CTRL_IDX) begin
            rdata <= {24'h000000, synth_active, synth_ctrl_ff[6:0]}; // see RQ11
         end else if (araddr[9:2] == `WAKE_CTRL_IDX) begin
            rdata <= {30'h00000000, disable_busy, wake_pend_ff};
         end else begin
            rdata <= 32'h00000000;
            rresp <= 2'h2;
         end
      end else if (rvalid && rready) begin
         rvalid <= 1'b0;
      end
   end

   // ----------------------------------------
   // Control registers
   // ----------------------------------------
   // Crystal halt is pinned high while the fuse disables the crystal input
   assign nxt_sys_ctrl = {wr_data[7:3],
                          wr_data[`SCC_XTAL_HALT] | !crystal_input_fuse,
                          wr_data[1:0]}; // see RQ8
   assign nxt_synth_ctrl = {1'b0, wr_data[6:0]};
   assign scheme_sw = sys_ctrl_ff[`SCC_SCHEME];

   always @(posedge aclk) begin
      if (!aresetn) begin
         sys_ctrl_ff <= `SYS_CLK_CTRL_RST; // see RQ1
         synth_ctrl_ff <= `SYNTH_CTRL_RST;
      end else begin
         if (wr_sys) begin
            sys_ctrl_ff <= nxt_sys_ctrl;
         end else if (!crystal_input_fuse) begin
            sys_ctrl_ff[`SCC_XTAL_HALT] <= 1'b1; // see RQ8
         end
         // Hardware set wins over a simultaneous software write
         if (wr_synth) begin
            synth_ctrl_ff <= nxt_synth_ctrl;
         end
         if (low_power_irq && (sub_active || stop_wake)) begin
            synth_ctrl_ff[`SYN_OUT_SEL] <= 1'b1; // see RQ12
         end
      end
   end

   // ----------------------------------------
   // Applied clock selection
   // ----------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) begin
         sys_src <= `SRC_INTERNAL_RC_OSCILLATOR; // see RQ1
         div_act_ff <= 2'h0;
         rc_halt_act_ff <= 1'b0;
         xtal_halt_act_ff <= 1'b1;
         wake_pend_ff <= 1'b0;
      end else begin
         if (scheme_sw) begin
            sys_src <= sys_ctrl_ff[`SCC_SRC_HI:`SCC_SRC_LO]; // see RQ5
            div_act_ff <= sys_ctrl_ff[`SCC_DIV_HI:`SCC_DIV_LO]; // see RQ5
            rc_halt_act_ff <= sys_ctrl_ff[`SCC_RC_HALT]; // see RQ7
            xtal_halt_act_ff <= sys_ctrl_ff[`SCC_XTAL_HALT]; // see RQ8
            wake_pend_ff <= 1'b0;
         end else begin
            rc_halt_act_ff <= 1'b0;
            xtal_halt_act_ff <= !crystal_input_fuse;
            if (stop_wake) begin
               sys_src <= sys_ctrl_ff[`SCC_SRC_HI:`SCC_SRC_LO]; // see RQ4
               div_act_ff <= sys_ctrl_ff[`SCC_DIV_HI:`SCC_DIV_LO]; // see RQ4
               wake_pend_ff <= 1'b0;
            end
            // A write in the wake cycle missed this wake, so it stays pending
            if (wr_sys) begin
               wake_pend_ff <= 1'b1;
            end
         end
      end
   end

   // ----------------------------------------
   // System clock strobe
   // ----------------------------------------
   assign rc_gated_tick = rc_tick && rc_osc_run;

   clk_divider u_rc_div (
      .aclk(aclk),
      .aresetn(aresetn),
      .tick_in(rc_gated_tick),
      .div_sel(div_act_ff),
      .tick_out(rc_div_tick)
   ); // see RQ3

   // Divider only matters on the RC path
   assign sys_clk_tick = (sys_src == `SRC_INTERNAL_RC_OSCILLATOR) ? rc_div_tick :
                         (sys_src == `SRC_XTAL) ? (xtal_tick && xtal_osc_run) :
                         (sys_src == `SRC_SUB_SYNTH) ? (synth_bypass ? sub_tick : synth_tick) :
                         ring_tick; // see RQ3 RQ9
   assign ring_osc_clock = ring_tick; // see RQ2

   // ----------------------------------------
   // Synthesizer control
   // ----------------------------------------
   assign synth_active = synth_ctrl_ff[`SYN_ENABLE] && synth_ctrl_ff[`SYN_OUT_SEL]; // see RQ11

   always @(posedge aclk) begin
      if (!aresetn) begin
         synth_en_d_ff <= 1'b0;
      end else begin
         synth_en_d_ff <= synth_ctrl_ff[`SYN_ENABLE];
      end
   end

   synth_disable_timer u_off_timer (
      .aclk(aclk),
      .aresetn(aresetn),
      .start(synth_en_d_ff && !synth_ctrl_ff[`SYN_ENABLE]),
      .sub_tick(sub_tick),
      .running(disable_busy)
   ); // see RQ17

   always @* begin
      case (synth_ctrl_ff[`SYN_FB_HI:`SYN_FB_LO])
         2'h0: feedback_ratio = `FB_RATIO_0; // see RQ15
         2'h1: feedback_ratio = `FB_RATIO_1;
         2'h2: feedback_ratio = `FB_RATIO_2;
         default: feedback_ratio = `FB_RATIO_3;
      endcase
      case (synth_ctrl_ff[`SYN_PD_HI:`SYN_PD_LO])
         2'h0: post_divider = 4'h1; // see RQ16
         2'h1: post_divider = 4'h2;
         2'h2: post_divider = 4'h4;
         default: post_divider = 4'h8;
      endcase
   end

   assign vco_freq = `REF_FREQ_HZ * {22'h000000, feedback_ratio};

   always @(posedge aclk) begin
      if (!aresetn) begin
         rc_osc_run <= 1'b1;
         xtal_osc_run <= 1'b0;
         synth_core_run <= 1'b0;
         synth_bypass <= 1'b1;
         main_regulator_on <= 1'b1;
         sub_regulator_on <= 1'b0;
         stop_deep <= 1'b0;
         sub_active <= 1'b0;
         synth_freq_hz <= 32'h00000000;
      end else begin
         rc_osc_run <= !rc_halt_act_ff; // see RQ7
         xtal_osc_run <= !xtal_halt_act_ff; // see RQ8
         // Core keeps running even while the bypass path is selected
         // Delayed enable bridges the cycle before the disable timer starts
         synth_core_run <= synth_ctrl_ff[`SYN_ENABLE] || synth_en_d_ff ||
                           disable_busy; // see RQ13 RQ17
         synth_bypass <= !synth_active; // see RQ12
         sub_active <= (sys_src == `SRC_SUB_SYNTH) && !synth_ctrl_ff[`SYN_OUT_SEL] &&
                       !synth_ctrl_ff[`SYN_ENABLE]; // see RQ18
         if ((sys_src == `SRC_SUB_SYNTH) && !synth_ctrl_ff[`SYN_OUT_SEL]) begin
            main_regulator_on <= synth_ctrl_ff[`SYN_ENABLE] &&
                                 synth_ctrl_ff[`SYN_REG_SEL]; // see RQ14
            sub_regulator_on <= !(synth_ctrl_ff[`SYN_ENABLE] &&
                                  synth_ctrl_ff[`SYN_REG_SEL]); // see RQ14 RQ18
         end else begin
            main_regulator_on <= 1'b1;
            sub_regulator_on <= 1'b0;
         end
         // Stop depth is meaningful only for the deep power-control code
         stop_deep <= (power_control_register == `STOP_DEEP_POWER_CONTROL_REGISTER) &&
                      !sys_ctrl_ff[`SCC_STOP_DEPTH]; // see RQ10
         synth_freq_hz <= synth_active ? (vco_freq >> (synth_ctrl_ff[`SYN_PD_HI:`SYN_PD_LO])) :
                          `REF_FREQ_HZ; // see RQ19
      end
   end
endmodule // sys_clk_ctrl

// ==== osc_sources.sv ====
// Purpose: Oscillator strobes seen by the clock control block
// Assumes: One aclk; each source is a strobe every few cycles
// Notes: A halted source gives no strobes, as a stopped crystal would
`timescale 1ns/100ps
module osc_sources (
   input wire aclk,
   input wire rc_run,
   input wire xtal_run,
   input wire synth_run,
   output logic rc_tick = 1'h0,
   output logic xtal_tick = 1'h0,
   output logic sub_tick = 1'h0,
   output logic synth_tick = 1'h0,
   output logic ring_tick = 1'h0
);
   int cnt = 0;
   // ------------------------------------
   // Strobes at fixed spacing
   // ------------------------------------
   always @(posedge aclk) begin
      cnt <= cnt + 1;
      rc_tick <= rc_run && (cnt % 2 == 1);
      xtal_tick <= xtal_run && (cnt % 3 == 2);
      sub_tick <= (cnt % 5 == 4);
      synth_tick <= synth_run && (cnt % 2 == 0);
      ring_tick <= (cnt % 4 == 3);
   end
endmodule // osc_sources

// ==== clk_ctrl_sva.sv ====
// Purpose: Port checks for the system clock control block
// Assumes: Single clock, synchronous active-low reset
// Notes: Attached by bind below
`timescale 1ns/100ps
`include "clkgen_consts.vh"
module clk_ctrl_checker (
   input wire aclk,
   input wire aresetn,
   input wire awvalid,
   input wire awready,
   input wire wvalid,
   input wire wready,
   input wire [1:0] bresp,
   input wire bvalid,
   input wire bready,
   input wire arvalid,
   input wire arready,
   input wire [31:0] rdata,
   input wire rvalid,
   input wire rready,
   input wire ring_tick,
   input wire ring_osc_clock,
   input wire crystal_input_fuse,
   input wire stop_wake,
   input wire [1:0] sys_src,
   input wire xtal_osc_run,
   input wire sub_active,
   input wire main_regulator_on,
   input wire sub_regulator_on,
   input wire [9:0] feedback_ratio,
   input wire [3:0] post_divider
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   logic [2:0] since_wr_ff;
   // ------------------------------------
   // Cycles since a write answer; a source may move only shortly after one or after a stop wake
   // ------------------------------------
   always @(posedge aclk) begin
      if (!aresetn) since_wr_ff <= 3'h7;
      else if ($rose(bvalid)) since_wr_ff <= 3'h0;
      else if (since_wr_ff != 3'h7) since_wr_ff <= since_wr_ff + 3'h1;
   end
   sequence s_wr; awvalid && awready && wvalid && wready; endsequence
   sequence s_rd; arvalid && arready; endsequence
   property p_bans; s_wr |=> bvalid; endproperty
   property p_bhold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
   property p_rans; s_rd |=> rvalid; endproperty
   property p_rhold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
   property p_ring; ring_osc_clock == ring_tick; endproperty
   property p_fb; feedback_ratio inside {10'h268, 10'h200, 10'h1c2, 10'h152}; endproperty
   property p_pd; post_divider inside {4'h1, 4'h2, 4'h4, 4'h8}; endproperty
   property p_src; $changed(sys_src) |-> $past(stop_wake) || since_wr_ff < 3'h6; endproperty
   property p_fuse;
      (!crystal_input_fuse && sys_src != `SRC_XTAL) [*3] |=> !xtal_osc_run;
   endproperty
   property p_subreg; sub_active |-> sub_regulator_on && !main_regulator_on; endproperty
   a_bans: assert property (p_bans) else $error("write not answered");
   a_bhold: assert property (p_bhold) else $error("write answer dropped");
   a_rans: assert property (p_rans) else $error("read not answered");
   a_rhold: assert property (p_rhold) else $error("read answer dropped");
   a_ring: assert property (p_ring) else $error("ring clock differs");
   a_fb: assert property (p_fb) else $error("bad feedback ratio");
   a_pd: assert property (p_pd) else $error("bad post divider");
   a_src: assert property (p_src) else $error("source moved unasked");
   a_fuse: assert property (p_fuse) else $error("crystal runs unfused");
   a_subreg: assert property (p_subreg) else $error("regulator wrong");
endmodule // clk_ctrl_checker
bind sys_clk_ctrl clk_ctrl_checker chk_i (.*);

// ==== testbench.sv ====
// Purpose: Register-level tests of the clock control block
// Assumes: AXI4-Lite master tasks, oscillator model beside the block
// Notes: Tick counts allow one strobe of phase slack
`timescale 1ns/100ps
`include "clkgen_consts.vh"
module testbench;
   logic aclk = 1'h0;
   logic aresetn = 1'h0;
   logic [31:0] awaddr = 32'h0, wdata = 32'h0, araddr = 32'h0;
   logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
   logic [3:0] wstrb = 4'hf;
   logic crystal_input_fuse = 1'h1, stop_wake = 1'h0, low_power_irq = 1'h0;
   logic [7:0] power_control_register = 8'h03;
   wire awready, wready, bvalid, arready, rvalid, sys_clk_tick, ring_osc_clock;
   wire rc_osc_run, xtal_osc_run, synth_core_run, synth_bypass, main_regulator_on;
   wire sub_regulator_on, stop_deep, sub_active;
   wire rc_tick, xtal_tick, sub_tick, synth_tick, ring_tick;
   wire [1:0] bresp, rresp, sys_src;
   wire [31:0] rdata, synth_freq_hz;
   wire [9:0] feedback_ratio;
   wire [3:0] post_divider;
   int n_errors = 0;
   int num_checks = 0;
   logic [31:0] ratio [4] = '{32'h268, 32'h200, 32'h1c2, 32'h152};
   initial begin
      forever #50 aclk = ~aclk;
   end
   sys_clk_ctrl dut (.*);
   osc_sources osc (.aclk(aclk), .rc_run(rc_osc_run), .xtal_run(xtal_osc_run),
      .synth_run(synth_core_run), .rc_tick(rc_tick), .xtal_tick(xtal_tick),
      .sub_tick(sub_tick), .synth_tick(synth_tick), .ring_tick(ring_tick));
   // ------------------------------------
   // Bus and compare tasks
   // ------------------------------------
   task automatic chk(input [31:0] got, input [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input [31:0] a, input [7:0] d, input [1:0] er);
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'h1;
      wvalid <= 1'h1;
      bready <= 1'h1;
      do begin
         @(posedge aclk);
         if (awready) awvalid <= 1'h0;
         if (wready) wvalid <= 1'h0;
      end while (!bvalid);
      bready <= 1'h0;
      chk(bresp, er);
   endtask
   task automatic rd(input [31:0] a, input [31:0] e, input [1:0] er);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'h1;
      rready <= 1'h1;
      do begin
         @(posedge aclk);
         if (arready) arvalid <= 1'h0;
      end while (!rvalid);
      rready <= 1'h0;
      chk(rdata, e);
      chk(rresp, er);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask
   task automatic ticks(input int e);
      int n;
      n = 0;
      repeat (96) begin
         @(posedge aclk);
         n += sys_clk_tick;
      end
      chk(n >= e - 1 && n <= e + 1, 32'h1);
   endtask
   task automatic pulse_wake;
      stop_wake <= 1'h1;
      @(posedge aclk);
      stop_wake <= 1'h0;
   endtask
   task automatic summarize;
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask
   // ------------------------------------
   // Watchdog, far beyond the thousand or so cycles the tests take
   // ------------------------------------
   initial begin
      cyc(20000);
      n_errors++;
      summarize;
   end
   // ------------------------------------
   // Tests
   // ------------------------------------
   initial begin
      cyc(12);
      aresetn <= 1'h1;
      rd(`SYS_CLK_CTRL_ADDR, 32'h04, 2'h0);
      rd(`SYNTH_CTRL_ADDR, 32'h00, 2'h0);
      chk({sys_src, rc_osc_run, xtal_osc_run}, 32'h3);
      chk(feedback_ratio, ratio[0]);
      chk(post_divider, 32'h1);
      ticks(48);
      rd(32'h100, 32'h0, 2'h2);
      wr(32'h104, 8'h55, 2'h2);
      // Deferred switch waits for wake from stop
      wr(`SYS_CLK_CTRL_ADDR, 8'h07, 2'h0);
      cyc(6);
      chk(sys_src, 32'h0);
      pulse_wake;
      cyc(3);
      chk(sys_src, 32'h3);
      ticks(24);
      for (int s = 0; s < 4; s++) begin
         wr(`SYS_CLK_CTRL_ADDR, 8'h10 | s[7:0], 2'h0);
         cyc(4);
         chk({sys_src, xtal_osc_run}, {s[1:0], 1'h1});
      end
      for (int d = 0; d < 4; d++) begin
         wr(`SYS_CLK_CTRL_ADDR, {1'h0, d[1:0], 5'h10}, 2'h0);
         cyc(4);
         ticks(48 >> d);
      end
      wr(`SYS_CLK_CTRL_ADDR, 8'h71, 2'h0);
      cyc(4);
      ticks(32);
      wr(`SYS_CLK_CTRL_ADDR, 8'h19, 2'h0);
      cyc(4);
      chk(rc_osc_run, 32'h0);
      wr(`SYS_CLK_CTRL_ADDR, 8'h10, 2'h0);
      crystal_input_fuse <= 1'h0;
      cyc(4);
      chk({rc_osc_run, xtal_osc_run}, 32'h2);
      crystal_input_fuse <= 1'h1;
      for (int f = 0; f < 4; f++) begin
         for (int p = 0; p < 4; p++) begin
            wr(`SYNTH_CTRL_ADDR, {3'h2, f[1:0], p[1:0], 1'h1}, 2'h0);
            cyc(4);
            chk(feedback_ratio, ratio[f]);
            chk(post_divider, 32'h1 << p);
            chk(synth_freq_hz, (32'h8000 * ratio[f]) >> p);
            rd(`SYNTH_CTRL_ADDR, {24'h0, 3'h6, f[1:0], p[1:0], 1'h1}, 2'h0);
         end
      end
      wr(`SYS_CLK_CTRL_ADDR, 8'h12, 2'h0);
      wr(`SYNTH_CTRL_ADDR, 8'h01, 2'h0);
      cyc(4);
      chk({synth_bypass, synth_core_run, sub_regulator_on, main_regulator_on}, 32'he);
      chk(synth_freq_hz, 32'h8000);
      rd(`SYNTH_CTRL_ADDR, 32'h01, 2'h0);
      wr(`SYNTH_CTRL_ADDR, 8'h21, 2'h0);
      cyc(4);
      chk({sub_regulator_on, main_regulator_on}, 32'h1);
      // Disable runs on sub-oscillator strobes, core stays up meanwhile
      wr(`SYNTH_CTRL_ADDR, 8'h00, 2'h0);
      chk(synth_core_run, 32'h1);
      cyc(1);
      chk(synth_core_run, 32'h1);
      cyc(20);
      chk({synth_core_run, sub_active, sub_regulator_on, main_regulator_on}, 32'h6);
      low_power_irq <= 1'h1;
      @(posedge aclk);
      low_power_irq <= 1'h0;
      cyc(3);
      rd(`SYNTH_CTRL_ADDR, 32'h40, 2'h0);
      for (int k = 0; k < 3; k++) begin
         power_control_register <= (k == 2) ? 8'h01 : 8'h03;
         wr(`SYS_CLK_CTRL_ADDR, {k[0], 7'h12}, 2'h0);
         cyc(3);
         chk(stop_deep, k == 0);
      end
      wr(`SYS_CLK_CTRL_ADDR, 8'h02, 2'h0);
      rd(`SYS_CLK_CTRL_ADDR, 32'h02, 2'h0);
      summarize;
   end
endmodule // testbench
